// [verilog/spsp_pkg.sv]
package spsp_pkg;
  // timing
  localparam int SPSP_CLK_PERIOD_NS = 100;
  localparam int SPSP_CFGCLK_HALF_NS = 500;
  localparam int SPSP_CFGCLK_HALF_CYC = (SPSP_CFGCLK_HALF_NS + SPSP_CLK_PERIOD_NS - 1) /
                                        SPSP_CLK_PERIOD_NS;
  localparam int SPSP_DIV_W = 4;
  localparam logic [SPSP_DIV_W-1:0] SPSP_DIV_LAST = 4'(SPSP_CFGCLK_HALF_CYC - 1);
  localparam logic [SPSP_DIV_W-1:0] SPSP_DIV_RST = 4'h0;
  // configuration memory access length in serial bits
  localparam int SPSP_FRAME_BITS = 16;
  localparam int SPSP_BITCNT_W = 5;
  localparam logic [SPSP_BITCNT_W-1:0] SPSP_BITCNT_RST = 5'h00;
  localparam logic [SPSP_BITCNT_W-1:0] SPSP_BITCNT_LAST = 5'(SPSP_FRAME_BITS - 1);
  localparam int SPSP_SR_W = 16;
  localparam logic [SPSP_SR_W-1:0] SPSP_SR_RST = 16'h0000;
  // reset values of the status pins
  localparam logic SPSP_POWER_ENABLE_N_N_RST = 1'b1;
  localparam logic SPSP_SUSP_N_RST = 1'b1;

  typedef enum logic [1:0] {
    SPSP_ST_UNCONF = 2'b00,
    SPSP_ST_ACTIVE = 2'b01,
    SPSP_ST_SUSP = 2'b10
  } spsp_state_t;
endpackage : spsp_pkg

// [verilog/spsp_cfgclk_div.sv]
`timescale 1ns/100ps
`default_nettype none
module spsp_cfgclk_div
  import spsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic tick_o
);
  logic [SPSP_DIV_W-1:0] cnt_r;
  logic [SPSP_DIV_W-1:0] cnt_nxt;
  logic tick_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (!run_i) begin
      cnt_nxt = SPSP_DIV_RST;
    end else if (cnt_r == SPSP_DIV_LAST) begin
      cnt_nxt = SPSP_DIV_RST;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= SPSP_DIV_RST;
      tick_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end
endmodule : spsp_cfgclk_div
`default_nettype wire

// [verilog/spsp_top.sv]
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - reset input is active low and holds all internal logic in reset
// - power enable low when configured and active, high when suspended or unconfigured
// - suspend output low while the link is suspended, high otherwise
// - power sense honoured only if option set; low forces suspend
// - forced suspend keeps usb data line drivers off
// - memory select floats during reset
// - memory clock floats during reset
// - after reset the memory clock is driven at all times, between accesses as well
// - memory data floats during reset, then serves both directions on one wire
module spsp_top
  import spsp_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic RESET_N_I,
  input wire logic HOST_CONFIGURED_I,
  input wire logic BUS_SUSPEND_I,
  input wire logic BUS_POWER_SENSE_N_I,
  input wire logic SENSE_ENABLE_I,
  input wire logic CFGMEM_START_I,
  input wire logic [SPSP_SR_W-1:0] CFGMEM_TX_I,
  input wire logic CFGMEM_DATA_I,
  output logic CFGMEM_DATA_O,
  output logic CFGMEM_DATA_OE_O,
  output logic CFGMEM_SELECT_O,
  output logic CFGMEM_SELECT_OE_O,
  output logic CFGMEM_CLOCK_O,
  output logic CFGMEM_CLOCK_OE_O,
  output logic [SPSP_SR_W-1:0] CFGMEM_RX_O,
  output logic CFGMEM_BUSY_O,
  output logic POWER_ENABLE_N_O,
  output logic SUSPEND_N_O,
  output logic USB_DRIVE_EN_O
);
  // either reset source holds the whole block
  logic rst;
  assign rst = SYS_RST_I | ~RESET_N_I;

  spsp_state_t st_r;
  spsp_state_t st_nxt;
  logic power_enable_n_n_nxt;
  logic susp_n_nxt;
  logic usb_en_nxt;
  logic force_susp;

  // power sense is ignored unless the self-powered option is on
  assign force_susp = SENSE_ENABLE_I & ~BUS_POWER_SENSE_N_I;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SPSP_ST_UNCONF: begin
        if (force_susp || BUS_SUSPEND_I) begin
          st_nxt = SPSP_ST_SUSP;
        end else if (HOST_CONFIGURED_I) begin
          st_nxt = SPSP_ST_ACTIVE;
        end
      end
      SPSP_ST_ACTIVE: begin
        if (force_susp || BUS_SUSPEND_I) begin
          st_nxt = SPSP_ST_SUSP;
        end else if (!HOST_CONFIGURED_I) begin
          st_nxt = SPSP_ST_UNCONF;
        end
      end
      SPSP_ST_SUSP: begin
        if (!force_susp && !BUS_SUSPEND_I) begin
          st_nxt = HOST_CONFIGURED_I ? SPSP_ST_ACTIVE : SPSP_ST_UNCONF;
        end
      end
      default: begin
        st_nxt = SPSP_ST_UNCONF;
      end
    endcase
    power_enable_n_n_nxt = (st_nxt != SPSP_ST_ACTIVE);
    susp_n_nxt = (st_nxt != SPSP_ST_SUSP);
    usb_en_nxt = (st_nxt != SPSP_ST_SUSP);
  end

  always_ff @(posedge REF_CLK_I or posedge rst) begin
    if (rst) begin
      st_r <= SPSP_ST_UNCONF;
      POWER_ENABLE_N_O <= SPSP_POWER_ENABLE_N_N_RST;
      SUSPEND_N_O <= SPSP_SUSP_N_RST;
      USB_DRIVE_EN_O <= 1'b0;
    end else begin
      st_r <= st_nxt;
      POWER_ENABLE_N_O <= power_enable_n_n_nxt;
      SUSPEND_N_O <= susp_n_nxt;
      USB_DRIVE_EN_O <= usb_en_nxt;
    end
  end

  // configuration memory serial engine
  logic tick;
  logic busy_r;
  logic busy_nxt;
  logic [SPSP_BITCNT_W-1:0] bit_r;
  logic [SPSP_BITCNT_W-1:0] bit_nxt;
  logic [SPSP_SR_W-1:0] tx_r;
  logic [SPSP_SR_W-1:0] tx_nxt;
  logic [SPSP_SR_W-1:0] rx_nxt;
  logic sclk_nxt;
  logic sel_nxt;
  logic dout_nxt;
  logic doe_nxt;
  logic oe_nxt;
  logic oe_r;

  spsp_cfgclk_div u_div (
    .clk_i(REF_CLK_I),
    .rst_i(rst),
    .run_i(busy_r),
    .tick_o(tick)
  );

  always_comb begin
    busy_nxt = busy_r;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    rx_nxt = CFGMEM_RX_O;
    sclk_nxt = CFGMEM_CLOCK_O;
    sel_nxt = CFGMEM_SELECT_O;
    dout_nxt = CFGMEM_DATA_O;
    doe_nxt = CFGMEM_DATA_OE_O;
    oe_nxt = 1'b1;
    if (!busy_r) begin
      if (CFGMEM_START_I) begin
        busy_nxt = 1'b1;
        bit_nxt = SPSP_BITCNT_RST;
        tx_nxt = CFGMEM_TX_I;
        sel_nxt = 1'b1;
        dout_nxt = CFGMEM_TX_I[SPSP_SR_W-1];
        doe_nxt = 1'b1;
      end
    end else if (tick) begin
      sclk_nxt = ~CFGMEM_CLOCK_O;
      if (!CFGMEM_CLOCK_O) begin
        // rising edge: sample the shared wire, a talking memory wins through the resistor
        rx_nxt = {CFGMEM_RX_O[SPSP_SR_W-2:0], CFGMEM_DATA_I};
      end else if (bit_r == SPSP_BITCNT_LAST) begin
        busy_nxt = 1'b0;
        sel_nxt = 1'b0;
        doe_nxt = 1'b0;
      end else begin
        bit_nxt = bit_r + 5'h01;
        tx_nxt = {tx_r[SPSP_SR_W-2:0], 1'b0};
        dout_nxt = tx_r[SPSP_SR_W-2];
      end
    end
  end

  always_ff @(posedge REF_CLK_I or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      bit_r <= SPSP_BITCNT_RST;
      tx_r <= SPSP_SR_RST;
      oe_r <= 1'b0;
      CFGMEM_RX_O <= SPSP_SR_RST;
      CFGMEM_CLOCK_O <= 1'b0;
      CFGMEM_SELECT_O <= 1'b0;
      CFGMEM_DATA_O <= 1'b0;
      CFGMEM_DATA_OE_O <= 1'b0;
      CFGMEM_SELECT_OE_O <= 1'b0;
      CFGMEM_CLOCK_OE_O <= 1'b0;
      CFGMEM_BUSY_O <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      bit_r <= bit_nxt;
      tx_r <= tx_nxt;
      oe_r <= oe_nxt;
      CFGMEM_RX_O <= rx_nxt;
      CFGMEM_CLOCK_O <= sclk_nxt;
      CFGMEM_SELECT_O <= sel_nxt;
      CFGMEM_DATA_O <= dout_nxt;
      CFGMEM_DATA_OE_O <= doe_nxt;
      CFGMEM_SELECT_OE_O <= oe_nxt;
      CFGMEM_CLOCK_OE_O <= oe_nxt;
      CFGMEM_BUSY_O <= busy_nxt;
    end
  end
endmodule : spsp_top
`default_nettype wire

// [tb/spsp_top_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module spsp_chk (
  input wire logic REF_CLK_I, SYS_RST_I, RESET_N_I, HOST_CONFIGURED_I, BUS_SUSPEND_I,
  input wire logic BUS_POWER_SENSE_N_I, SENSE_ENABLE_I, CFGMEM_DATA_OE_O,
  input wire logic CFGMEM_SELECT_OE_O, CFGMEM_CLOCK_OE_O, POWER_ENABLE_N_O, SUSPEND_N_O,
  input wire logic USB_DRIVE_EN_O
);
  wire logic up = !SYS_RST_I && RESET_N_I;
  wire logic s = BUS_SUSPEND_I | (SENSE_ENABLE_I & ~BUS_POWER_SENSE_N_I);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_rst_hold: assert property (!RESET_N_I |-> POWER_ENABLE_N_O && SUSPEND_N_O)
    else $error("status not held");
  a_sel_float: assert property (!RESET_N_I |-> !CFGMEM_SELECT_OE_O)
    else $error("select driven");
  a_clk_float: assert property (!RESET_N_I |-> !CFGMEM_CLOCK_OE_O)
    else $error("clock driven");
  a_data_float: assert property (!RESET_N_I |-> !CFGMEM_DATA_OE_O)
    else $error("data driven");
  a_clk_drive: assert property (up && $past(up) |-> CFGMEM_CLOCK_OE_O)
    else $error("clock not driven");
  a_susp_level: assert property (up && $past(up) |-> SUSPEND_N_O == !$past(s))
    else $error("suspend level");
  a_power_enable_n_level: assert property (up && $past(up) |->
    POWER_ENABLE_N_O == !($past(HOST_CONFIGURED_I) && !$past(s))) else $error("power level");
  a_usb_quiet: assert property (up && $past(up && s) |-> !USB_DRIVE_EN_O)
    else $error("usb driven");
endmodule : spsp_chk
bind spsp_top spsp_chk chk_u (.*);
`default_nettype wire

// [tb/spsp_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module spsp_mem_model #(parameter logic [15:0] REPLY = 16'hA5C3) (
  input wire logic sel_i,
  input wire logic clk_i,
  input wire logic din_i,
  output logic [15:0] got_o,
  output logic q_o
);
  logic [15:0] out_r;
  // the memory takes what the device drives on each rising clock
  always @(posedge clk_i) if (sel_i) got_o <= {got_o[14:0], din_i};
  always @(posedge sel_i) out_r = REPLY;
  always @(negedge clk_i) if (sel_i) out_r <= out_r << 1;
  // reply overrides the device via the series resistor; idle wire rests on the pull-up
  assign q_o = sel_i ? out_r[15] : 1'b1;
endmodule : spsp_mem_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t mismatch", $time); end end
module tb_top;
  logic clk = 0, SYS_RST_I = 1, RESET_N_I = 1, HOST_CONFIGURED_I = 0, BUS_SUSPEND_I = 0;
  logic BUS_POWER_SENSE_N_I = 1, SENSE_ENABLE_I = 0, CFGMEM_START_I = 0;
  logic [15:0] CFGMEM_TX_I = 16'h9C35;
  wire logic REF_CLK_I = clk;
  wire logic CFGMEM_DATA_I, CFGMEM_DATA_O, CFGMEM_DATA_OE_O, CFGMEM_SELECT_O, CFGMEM_BUSY_O;
  wire logic CFGMEM_SELECT_OE_O, CFGMEM_CLOCK_O, CFGMEM_CLOCK_OE_O, POWER_ENABLE_N_O;
  wire logic SUSPEND_N_O, USB_DRIVE_EN_O;
  wire logic [15:0] CFGMEM_RX_O;
  wire logic [15:0] mem_got;
  int n_mismatch = 0, comparisons = 0;
  spsp_top dut_u (.*);
  spsp_mem_model mem_u (.sel_i(CFGMEM_SELECT_O & CFGMEM_SELECT_OE_O),
    .clk_i(CFGMEM_CLOCK_O & CFGMEM_CLOCK_OE_O), .din_i(CFGMEM_DATA_O & CFGMEM_DATA_OE_O),
    .got_o(mem_got), .q_o(CFGMEM_DATA_I));
  initial forever #50 clk = ~clk;
  task finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  task t_reset;
    @(posedge clk) RESET_N_I <= 0;
    @(negedge clk);
    `CHK({CFGMEM_SELECT_OE_O, CFGMEM_CLOCK_OE_O, CFGMEM_DATA_OE_O}, 3'h0)
    `CHK({POWER_ENABLE_N_O, SUSPEND_N_O, USB_DRIVE_EN_O, CFGMEM_BUSY_O}, 4'hC)
    @(posedge clk) RESET_N_I <= 1;
    $display("reset test done");
  endtask : t_reset
  task t_status;
    logic s;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk) {HOST_CONFIGURED_I, BUS_SUSPEND_I, SENSE_ENABLE_I, BUS_POWER_SENSE_N_I}
        <= 4'(k); // sense high stands for bus supply present
      @(posedge clk);
      @(negedge clk);
      s = BUS_SUSPEND_I | (SENSE_ENABLE_I & ~BUS_POWER_SENSE_N_I);
      `CHK(SUSPEND_N_O, ~s)
      `CHK(POWER_ENABLE_N_O, ~(HOST_CONFIGURED_I & ~s))
      if (s) `CHK(USB_DRIVE_EN_O, 1'b0)
      else `CHK(USB_DRIVE_EN_O, 1'b1)
    end
    $display("status test done");
  endtask : t_status
  task t_mem;
    int i;
    @(posedge clk) CFGMEM_START_I <= 1;
    repeat (3) @(posedge clk);
    CFGMEM_START_I <= 0;
    @(negedge clk);
    `CHK({CFGMEM_BUSY_O, CFGMEM_SELECT_O, CFGMEM_DATA_OE_O, CFGMEM_DATA_O}, 4'hF)
    for (i = 0; i < 400 && CFGMEM_BUSY_O === 1'b1; i++)
      @(negedge clk);
    @(negedge clk);
    `CHK({CFGMEM_BUSY_O, CFGMEM_RX_O}, {1'b0, 16'hA5C3})
    `CHK(mem_got, 16'h9C35)
    `CHK({CFGMEM_SELECT_O, CFGMEM_DATA_OE_O, CFGMEM_CLOCK_O, CFGMEM_CLOCK_OE_O}, 4'h1)
    $display("memory test done");
  endtask : t_mem
  initial begin
    repeat (3) @(posedge clk);
    SYS_RST_I <= 0;
    t_reset();
    t_status();
    t_mem();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
